// file: rtl/tpc_top.sv
/*
 * Eight-channel transmit path configuration bank with an APB slave.
 * It assumes an APB master on CLK_I and transmit datapaths that take the decoded controls.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module tpc_top (
    input  wire logic                                CLK_I,
    input  wire logic                                RST_I,
    input  wire logic                                PSEL_I,
    input  wire logic                                PENABLE_I,
    input  wire logic                                PWRITE_I,
    input  wire logic [31:0]                         PADDR_I,
    input  wire logic [31:0]                         PWDATA_I,
    output logic      [31:0]                         PRDATA_O,
    output logic                                     PREADY_O,
    output logic                                     PSLVERR_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_PWR_DOWN_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          LINE_DRIVER_TRISTATE_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_DATA_POLARITY_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_SAMPLE_EDGE_SEL_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_DUAL_RAIL_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_ENC_LINE_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          TX_ENC_AMI_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          DRIVER_FAIL_MONITOR_EN_O,
    output logic      [tpc_pkg::NUM_CH-1:0]          USER_WAVE_O,
    output logic      [tpc_pkg::NUM_CH*4-1:0]        PULSE_TEMPLATE_SEL_O
);
    import tpc_pkg::*;

    // ********************************************************************
    // Address decode
    // ********************************************************************
    logic [ADDR_W-1:0] reg_idx;
    logic [CH_W-1:0]   ch_sel;
    logic [4:0]        ofs;
    logic              hit_a;
    logic              hit_b;
    logic              upper_zero;
    logic              access;

    // Each register owns one aligned word, so the byte-lane bits are dropped.
    assign reg_idx    = PADDR_I[ADDR_W+BYTE_SHIFT-1:BYTE_SHIFT];
    assign ch_sel     = reg_idx[ADDR_W-1:ADDR_W-CH_W];
    assign ofs        = reg_idx[4:0] & OFS_MASK;
    assign upper_zero = (PADDR_I[31:ADDR_W+BYTE_SHIFT] == '0);
    assign hit_a      = upper_zero && (ofs == OFS_CTRL_A[4:0]);
    assign hit_b      = upper_zero && (ofs == OFS_CTRL_B[4:0]);
    assign access     = PSEL_I && PENABLE_I;

    // Zero-wait slave: every access phase completes at its first edge.
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = access && !(hit_a || hit_b);

    // ********************************************************************
    // Register file
    // ********************************************************************
    logic [REG_W-1:0] ctrl_a_q [NUM_CH];
    logic [REG_W-1:0] ctrl_a_d [NUM_CH];
    logic [REG_W-1:0] ctrl_b_q [NUM_CH];
    logic [REG_W-1:0] ctrl_b_d [NUM_CH];
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ctrl_a_d[i] = ctrl_a_q[i];
            ctrl_b_d[i] = ctrl_b_q[i];
            if (access && PWRITE_I && (ch_sel == CH_W'(i))) begin
                if (hit_a) begin
                    ctrl_a_d[i] = PWDATA_I[REG_W-1:0] & A_WR_MASK;
                end
                // Reserved top bits of transmit_control_b are stored as written so software sees them; those of transmit_control_a are dropped.
                if (hit_b) begin
                    ctrl_b_d[i] = PWDATA_I[REG_W-1:0] & B_WR_MASK;
                end
            end
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            prdata_d = 32'h00000000;
            if (hit_a) begin
                prdata_d = {24'h000000, ctrl_a_q[ch_sel]};
            end else if (hit_b) begin
                prdata_d = {24'h000000, ctrl_b_q[ch_sel]};
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_a_q[i] <= A_RESET;
                ctrl_b_q[i] <= B_RESET;
            end
            prdata_q <= 32'h00000000;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl_a_q[i] <= ctrl_a_d[i];
                ctrl_b_q[i] <= ctrl_b_d[i];
            end
            prdata_q <= prdata_d;
        end
    end

    assign PRDATA_O = prdata_q;

    // ********************************************************************
    // Per-channel decode
    // ********************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tpc_cfg_if cfg_bus ();
            assign cfg_bus.ctrl_a = ctrl_a_q[g];
            assign cfg_bus.ctrl_b = ctrl_b_q[g];
            tpc_chan u_chan (
                .cfg            (cfg_bus.chan),
                .pwr_down_o     (TX_PWR_DOWN_O[g]),
                .drv_tristate_o (LINE_DRIVER_TRISTATE_O[g]),
                .data_inv_o     (TX_DATA_POLARITY_O[g]),
                .rise_edge_o    (TX_SAMPLE_EDGE_SEL_O[g]),
                .dual_rail_o    (TX_DUAL_RAIL_O[g]),
                .enc_line_o     (TX_ENC_LINE_O[g]),
                .enc_ami_o      (TX_ENC_AMI_O[g]),
                .dfm_enable_o   (DRIVER_FAIL_MONITOR_EN_O[g]),
                .user_wave_o    (USER_WAVE_O[g]),
                .template_o     (PULSE_TEMPLATE_SEL_O[g*4 +: 4])
            );
        end
    endgenerate

endmodule

// file: rtl/tpc_pkg.sv
/*
 * Package for the eight-channel transmit path configuration bank.
 * It holds the register map, the field positions, the reset values and the mode codes.
 * It assumes nothing about its surroundings.
 */
package tpc_pkg;

    // ********************************************************************
    // Sizes
    // ********************************************************************
    localparam int NUM_CH       = 8;
    localparam int CH_W         = 3;
    localparam int REG_W        = 8;
    localparam int ADDR_W       = 8;
    localparam int BYTE_SHIFT   = 2;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [ADDR_W-1:0] CH_STRIDE   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CTRL_A  = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B  = 8'h03;
    localparam logic [4:0]        OFS_MASK    = 5'h1F;

    // ********************************************************************
    // Field positions of transmit_control_a
    // ********************************************************************
    localparam int A_PWRDN_BIT  = 4;
    localparam int A_POL_BIT    = 3;
    localparam int A_EDGE_BIT   = 2;
    localparam int A_MODE_HI    = 1;
    localparam int A_MODE_LO    = 0;
    localparam logic [REG_W-1:0] A_RESET   = 8'h00;
    localparam logic [REG_W-1:0] A_WR_MASK = 8'h1F;

    // ********************************************************************
    // Field positions of transmit_control_b
    // ********************************************************************
    localparam int B_DRIVER_FAIL_MON_DISABLE_BIT = 5;
    localparam int B_TRIST_BIT   = 4;
    localparam int B_PULSE_TEMPLATE_SEL_HI     = 3;
    localparam int B_PULSE_TEMPLATE_SEL_LO     = 0;
    localparam logic [REG_W-1:0] B_RESET   = 8'h10;
    localparam logic [REG_W-1:0] B_WR_MASK = 8'hFF;

    // ********************************************************************
    // Encoder modes
    // ********************************************************************
    localparam logic [1:0] MODE_HDB3_B8ZS = 2'h0;
    localparam logic [1:0] MODE_AMI       = 2'h1;
    localparam logic [3:0] PULSE_TEMPLATE_SEL_USER_MSB2 = 4'hC;

    typedef enum logic [2:0] {
        TPC_ENC_LINE = 3'b001,
        TPC_ENC_AMI  = 3'b010,
        TPC_ENC_BYP  = 3'b100
    } tpc_enc_e;

endpackage

// file: rtl/tpc_cfg_if.sv
/*
 * Interface carrying one channel's two stored configuration registers.
 * It assumes one clock shared by the register file and the channel decode.
 */
`timescale 1ns/100ps
interface tpc_cfg_if;
    import tpc_pkg::*;
    logic [REG_W-1:0] ctrl_a;
    logic [REG_W-1:0] ctrl_b;
    modport regs (output ctrl_a, output ctrl_b);
    modport chan (input ctrl_a, input ctrl_b);
endinterface

// file: rtl/tpc_chan.sv
/*
 * Decode of one channel's configuration into transmit path controls.
 * It assumes the stored fields arrive through the channel modport.
 */
`timescale 1ns/100ps
module tpc_chan (
    tpc_cfg_if.chan         cfg,
    output logic            pwr_down_o,
    output logic            drv_tristate_o,
    output logic            data_inv_o,
    output logic            rise_edge_o,
    output logic            dual_rail_o,
    output logic            enc_line_o,
    output logic            enc_ami_o,
    output logic            dfm_enable_o,
    output logic            user_wave_o,
    output logic [3:0]      template_o
);
    import tpc_pkg::*;

    tpc_enc_e enc;

    always_comb begin
        case (cfg.ctrl_a[A_MODE_HI:A_MODE_LO])
            MODE_HDB3_B8ZS: enc = TPC_ENC_LINE;
            MODE_AMI:       enc = TPC_ENC_AMI;
            default:        enc = TPC_ENC_BYP;
        endcase
    end

    // Power-down forces the driver off as well as the transmitter.
    assign pwr_down_o     = cfg.ctrl_a[A_PWRDN_BIT];
    assign drv_tristate_o = cfg.ctrl_a[A_PWRDN_BIT] | cfg.ctrl_b[B_TRIST_BIT];
    assign data_inv_o     = cfg.ctrl_a[A_POL_BIT];
    assign rise_edge_o    = cfg.ctrl_a[A_EDGE_BIT];
    assign enc_line_o     = (enc == TPC_ENC_LINE);
    assign enc_ami_o      = (enc == TPC_ENC_AMI);
    assign dual_rail_o    = (enc == TPC_ENC_BYP);
    assign dfm_enable_o   = ~cfg.ctrl_b[B_DRIVER_FAIL_MON_DISABLE_BIT];
    assign template_o     = cfg.ctrl_b[B_PULSE_TEMPLATE_SEL_HI:B_PULSE_TEMPLATE_SEL_LO];
    assign user_wave_o    = (template_o & PULSE_TEMPLATE_SEL_USER_MSB2) == PULSE_TEMPLATE_SEL_USER_MSB2;

endmodule

// file: tb/tpc_chk.sv
/* Assertion checker for the transmit path configuration bank.
   It assumes it is bound to tpc_top and sees only that module's ports. */
`timescale 1ns/100ps
module tpc_chk (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PSLVERR_O,
    input wire logic [7:0]  TX_PWR_DOWN_O,
    input wire logic [7:0]  LINE_DRIVER_TRISTATE_O,
    input wire logic [7:0]  TX_DATA_POLARITY_O,
    input wire logic [7:0]  TX_SAMPLE_EDGE_SEL_O,
    input wire logic [7:0]  TX_DUAL_RAIL_O,
    input wire logic [7:0]  TX_ENC_LINE_O,
    input wire logic [7:0]  TX_ENC_AMI_O,
    input wire logic [7:0]  DRIVER_FAIL_MONITOR_EN_O,
    input wire logic [7:0]  USER_WAVE_O,
    input wire logic [31:0] PULSE_TEMPLATE_SEL_O
);
    // ********
    // Properties
    // ********
    logic wa, wb, w7;
    assign wa = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 32'h08;
    assign wb = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 32'h0C;
    assign w7 = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 32'h388;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_rst; $fell(RST_I) |-> (LINE_DRIVER_TRISTATE_O & DRIVER_FAIL_MONITOR_EN_O) == 8'hFF; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_pd; wa |=> TX_PWR_DOWN_O[0] == $past(PWDATA_I[4]); endproperty
    a_pd: assert property (p_pd) else $error("power down not written");
    property p_pdz; (TX_PWR_DOWN_O & ~LINE_DRIVER_TRISTATE_O) == 8'h00; endproperty
    a_pdz: assert property (p_pdz) else $error("powered down driver not tristated");
    property p_pol; wa |=> {TX_DATA_POLARITY_O[0], TX_SAMPLE_EDGE_SEL_O[0]} == $past(PWDATA_I[3:2]); endproperty
    a_pol: assert property (p_pol) else $error("polarity or edge wrong");
    property p_mode; wa |=> {TX_DUAL_RAIL_O[0], TX_ENC_AMI_O[0], TX_ENC_LINE_O[0]}
        == ($past(PWDATA_I[1]) ? 3'h4 : $past(PWDATA_I[0]) ? 3'h2 : 3'h1); endproperty
    a_mode: assert property (p_mode) else $error("encoder mode wrong");
    property p_b; wb |=> DRIVER_FAIL_MONITOR_EN_O[0] != $past(PWDATA_I[5])
        && PULSE_TEMPLATE_SEL_O[3:0] == $past(PWDATA_I[3:0]); endproperty
    a_b: assert property (p_b) else $error("monitor or template wrong");
    property p_tri; wb |=> LINE_DRIVER_TRISTATE_O[0] == ($past(PWDATA_I[4]) | TX_PWR_DOWN_O[0]); endproperty
    a_tri: assert property (p_tri) else $error("tristate wrong");
    property p_user; USER_WAVE_O[7:6] == {&PULSE_TEMPLATE_SEL_O[31:30], &PULSE_TEMPLATE_SEL_O[27:26]}; endproperty
    a_user: assert property (p_user) else $error("user wave flag wrong");
    property p_ch7; w7 |=> TX_PWR_DOWN_O[7] == $past(PWDATA_I[4]); endproperty
    a_ch7: assert property (p_ch7) else $error("channel stride wrong");
    property p_err; PSEL_I && PENABLE_I && PADDR_I[31:10] != 22'h0 |-> PSLVERR_O; endproperty
    a_err: assert property (p_err) else $error("unmapped access not flagged");
    c_wa: cover property (wa);
    c_wb: cover property (wb);
    c_err: cover property (PSLVERR_O);
endmodule
bind tpc_top tpc_chk u_chk (.*);

// file: tb/transmit_path_config_tb_top.sv
/* Self-checking bench for the transmit path configuration bank.
   It assumes tpc_top answers APB and decodes every channel combinationally. */
`timescale 1ns/100ps
module transmit_path_config_tb_top;
    import tpc_pkg::*;
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, tmpl;
    logic        pready, pslverr;
    logic [7:0]  pd, tz, pol, edg, dual, eline, eami, driver_fail_monitor, uw;
    logic [7:0]  ma [8], mb [8];
    logic [31:0] bad [4] = '{32'h00, 32'h24, 32'h1F, 32'h408};
    logic [32:0] exp_q [$];
    logic [32:0] e;
    int          mismatches = 0, tests_run = 0, cyc = 0, seed = 32'h62525773;
    tpc_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TX_PWR_DOWN_O(pd), .LINE_DRIVER_TRISTATE_O(tz),
        .TX_DATA_POLARITY_O(pol), .TX_SAMPLE_EDGE_SEL_O(edg), .TX_DUAL_RAIL_O(dual),
        .TX_ENC_LINE_O(eline), .TX_ENC_AMI_O(eami), .DRIVER_FAIL_MONITOR_EN_O(driver_fail_monitor),
        .USER_WAVE_O(uw), .PULSE_TEMPLATE_SEL_O(tmpl));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            stop_test;
        end
    end
    // Every access phase is checked at its completing edge against the oldest note.
    always @(posedge clk) if (psel && pen && pready === 1'b1) begin
        e = exp_q.pop_front();
        `CHK("pslverr", e[32], pslverr)
        if (!pwr) `CHK("prdata", e[31:0], prdata)
    end
    // Byte address of a channel register: four times its word index.
    function automatic logic [31:0] ra(input int n, input logic b);
        return 32'(4 * (32'h20 * n + 32'h02 + int'(b)));
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        exp_q.push_back(x);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, x);
    endtask
    task automatic chk_out;
        for (int n = 0; n < 8; n++) begin
            `CHK("pwr_down", ma[n][4], pd[n])
            `CHK("tristate", ma[n][4] | mb[n][4], tz[n])
            `CHK("polarity", ma[n][3], pol[n])
            `CHK("edge", ma[n][2], edg[n])
            `CHK("enc_line", ma[n][1:0] == 2'b00, eline[n])
            `CHK("enc_ami", ma[n][1:0] == 2'b01, eami[n])
            `CHK("dual_rail", ma[n][1], dual[n])
            `CHK("dfm_en", !mb[n][5], driver_fail_monitor[n])
            `CHK("template", mb[n][3:0], tmpl[4*n +: 4])
            `CHK("user_wave", &mb[n][3:2], uw[n])
        end
    endtask
    // ********
    // Stimulus
    // ********
    initial begin
        logic [7:0] va, vb;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int n = 0; n < 8; n++) begin
            ma[n] = 8'h00;
            mb[n] = 8'h10;
            rd(ra(n, 1'b0), 33'h000000000);
            rd(ra(n, 1'b1), 33'h000000010);
        end
        chk_out;
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            for (int m = 0; m < 4; m++) begin
                va = 8'($random(seed));
                vb = (8'($random(seed)) & 8'h33) | 8'(m << 2);
                apb(1'b1, ra(n, 1'b0), {24'h0, va[7:2], 2'(m)}, 33'h0);
                apb(1'b1, ra(n, 1'b1), {24'h0, vb}, 33'h0);
                ma[n] = {3'b000, va[4:2], 2'(m)};
                mb[n] = vb;
                chk_out;
                rd(ra(n, 1'b0), {25'h0, ma[n]});
                rd(ra(n, 1'b1), {25'h0, mb[n]});
            end
        end
        $display("test channel fields done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, bad[i], 32'hFF, {1'b1, 32'h0});
            rd(bad[i], {1'b1, 32'h0});
        end
        chk_out;
        $display("test unmapped done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int n = 0; n < 8; n++) begin
            ma[n] = 8'h00;
            mb[n] = 8'h10;
        end
        chk_out;
        rd(ra(7, 1'b0), 33'h000000000);
        rd(ra(7, 1'b1), 33'h000000010);
        $display("test mid-run reset done");
        stop_test;
    end
endmodule
